// *** verilog/mwic_device.sv ***
// Memory device end: configuration register writes, soft reset, calibration.
`include "mwic_defines.svh"
//
// Behaviour
// - Write recognised: select low, lines 3..0 low.
// - Address is falling 1..0 over rising 9..4.
// - Stored byte comes from falling lines 9..2.
// - Controller sends only no-ops during write period.
// - Writes to read-only registers change nothing.
// - Controller writes only with all banks precharged.
// - Address 63 soft-resets and restores register defaults.
// - Controller soft-resets only from idle.
// - Controller waits reset period, then boot timings.
// - Array contents undefined after soft reset.
// - Register 10 selects one of four calibrations.
// - Controller runs initial calibration; long recalibrates.
// - Controller should run short calibrations periodically.
// - Calibration only while idle, banks precharged.
// - Data bus quiet during non-default calibrations.
// - Clock gate high, only no-ops during calibration.
// - Shared reference: no overlapping non-default calibrations.
// - Reference pin current off after calibration.
// - Reference tied to supply: ignore calibration.
module mwic_device
  import mwic_pkg::*;
#(
  parameter logic [7:0] CODE_INIT  = `MWIC_CODE_INIT,   // Initial calibration code.
  parameter logic [7:0] CODE_DFLT  = `MWIC_CODE_DFLT,   // Reset-to-default code.
  parameter logic [7:0] CODE_LONG  = `MWIC_CODE_LONG,   // Long calibration code.
  parameter logic [7:0] CODE_SHORT = `MWIC_CODE_SHORT   // Short calibration code.
) (
  input  wire logic       clk,               // 250 MHz clock.
  input  wire logic       reset,             // Synchronous, active high.
  mwic_ca_if.dev          ca,                // Command/address link.
  input  wire logic       zqTiedToSupply,    // Reference pin strapped to the core rail.
  input  wire logic [5:0] rdAddr,            // Register to show on rdData.
  output logic      [7:0] rdData,            // Registered register contents.
  output logic            busy,              // Any write, reset or calibration period.
  output logic            calActive,         // A calibration period is running.
  output mwic_cal_t       calKind,           // Calibration now running.
  output logic            zqCurrentOn,       // Reference pin current path enabled.
  output logic            driverCalibrated,  // Drivers hold a calibrated setting.
  output logic            arrayLost,         // Pulse: array contents now undefined.
  output logic            cmdViolation       // Pulse: non-no-op during a busy period.
);

  // ========================================================================
  // Strap synchroniser
  // ========================================================================
  logic zqMeta_q;
  logic zqTied_q;

  // The strap is a board level, so it is treated as asynchronous.
  always_ff @(posedge clk) begin
    if (reset) begin
      zqMeta_q <= 1'b0;
      zqTied_q <= 1'b0;
    end else begin
      zqMeta_q <= zqTiedToSupply;
      zqTied_q <= zqMeta_q;
    end
  end

  // ========================================================================
  // Command decode
  // ========================================================================
  logic      isWrite;
  logic      isNop;
  logic [7:0] wrAddr;
  logic [7:0] wrData;
  mwic_cal_t reqCal;
  mwic_dev_state_t state_q;
  mwic_dev_state_t state_d;
  logic      accept;
  logic      softReset;
  logic      regWritable;

  // Deselect or the no-op opcode both count as a no-op.
  assign isNop = ca.csN | (ca.caRise[2:0] == `MWIC_NOP_CODE);
  assign isWrite = ~ca.csN & (ca.caRise[`MWIC_OPC_HI:0] == 4'h0);
  assign wrAddr = {ca.caFall[`MWIC_FADDR_HI:0],
                   ca.caRise[`MWIC_RADDR_HI:`MWIC_RADDR_LO]};
  assign wrData = ca.caFall[`MWIC_DATA_HI:`MWIC_DATA_LO];

  // A write is only honoured from idle; the controller keeps the gaps.
  assign accept = isWrite & (state_q == DEV_IDLE);
  assign softReset = accept & (wrAddr == `MWIC_SOFT_RESET_ADDR);

  // Unknown codes and a strapped reference both fall back to no calibration.
  always_comb begin
    reqCal = mwicCalKind(wrAddr, wrData, CODE_INIT, CODE_DFLT,
                         CODE_LONG, CODE_SHORT);
    if (zqTied_q) begin
      reqCal = CAL_NONE;
    end
  end

  // Only registers inside the file and not marked read-only take data.
  localparam logic [63:0] roMask = `MWIC_RO_MASK;
  assign regWritable = (wrAddr[7:6] == 2'b00) & ~roMask[wrAddr[5:0]];

  // ========================================================================
  // Period sequencer
  // ========================================================================
  logic [11:0] cnt_q;
  logic [11:0] cnt_d;
  logic [11:0] waitCyc;
  mwic_cal_t   kind_q;
  mwic_cal_t   kind_d;

  assign waitCyc = mwicWaitCycles(wrAddr, reqCal);

  // The command edge itself is cycle zero, so the counter holds one less.
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    kind_d = kind_q;
    case (state_q)
      DEV_IDLE: begin
        if (accept && (waitCyc > 12'h001)) begin
          cnt_d = waitCyc - 12'h001;
          kind_d = reqCal;
          if (softReset) begin
            state_d = DEV_RESETTING;
          end else if (reqCal != CAL_NONE) begin
            state_d = DEV_CAL;
          end else begin
            state_d = DEV_CFG_WAIT;
          end
        end
      end
      DEV_CFG_WAIT, DEV_CAL, DEV_RESETTING: begin
        if (cnt_q == 12'h001) begin
          state_d = DEV_IDLE;
          kind_d = CAL_NONE;
          cnt_d = 12'h000;
        end else begin
          cnt_d = cnt_q - 12'h001;
        end
      end
      default: begin
        state_d = DEV_IDLE;
        kind_d = CAL_NONE;
        cnt_d = 12'h000;
      end
    endcase
  end

  // State, count and running operation.
  always_ff @(posedge clk) begin
    if (reset) begin
      state_q <= DEV_IDLE;
      cnt_q <= 12'h000;
      kind_q <= CAL_NONE;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      kind_q <= kind_d;
    end
  end

  // ========================================================================
  // Configuration register file
  // ========================================================================
  logic [7:0] regs_q [`MWIC_NUM_REGS];

  // Soft reset outranks the write that carries it: all return to default.
  always_ff @(posedge clk) begin
    if (reset || softReset) begin
      for (int i = 0; i < `MWIC_NUM_REGS; i++) begin
        regs_q[i] <= `MWIC_REG_DEFAULT;
      end
    end else if (accept && regWritable) begin
      regs_q[wrAddr[5:0]] <= wrData;
    end
  end

  // Readback is registered so the user side sees a clean flop output.
  always_ff @(posedge clk) begin
    if (reset) begin
      rdData <= 8'h00;
    end else begin
      rdData <= regs_q[rdAddr];
    end
  end

  // ========================================================================
  // Calibration and driver status
  // ========================================================================
  logic calDone;

  assign calDone = (state_q == DEV_CAL) & (cnt_q == 12'h001);

  // Drivers count as calibrated after a full calibration; a default
  // calibration or a soft reset puts them back on the default setting.
  always_ff @(posedge clk) begin
    if (reset || softReset || zqTied_q) begin
      driverCalibrated <= 1'b0;
    end else if (calDone) begin
      driverCalibrated <= (kind_q != CAL_DFLT);
    end
  end

  // The reference current flows only inside a calibration period.
  always_ff @(posedge clk) begin
    if (reset) begin
      zqCurrentOn <= 1'b0;
    end else if (state_d == DEV_CAL) begin
      zqCurrentOn <= 1'b1;
    end else begin
      zqCurrentOn <= 1'b0;
    end
  end

  // ========================================================================
  // Event pulses
  // ========================================================================
  // The array is not cleared; the pulse only tells the user to stop
  // trusting it, which is cheaper than a full scrub.
  always_ff @(posedge clk) begin
    if (reset) begin
      arrayLost <= 1'b0;
      cmdViolation <= 1'b0;
    end else begin
      arrayLost <= softReset;
      cmdViolation <= (state_q != DEV_IDLE) & ~isNop;
    end
  end

  // Status views of the sequencer state.
  assign busy = (state_q != DEV_IDLE);
  assign calActive = (state_q == DEV_CAL);
  assign calKind = kind_q;

endmodule

// *** verilog/mwic_defines.svh ***
// Constants for the configuration write and impedance calibration block.
`ifndef MWIC_DEFINES_SVH
`define MWIC_DEFINES_SVH

// ==========================================================================
// Clock and timing
// ==========================================================================
`define MWIC_CLK_NS          4
// Least times round up to whole cycles.
`define MWIC_CYC(ns)         12'(((ns) + `MWIC_CLK_NS - 1) / `MWIC_CLK_NS)
`define MWIC_CFG_WRITE_CYC   12'h005
`define MWIC_RESET_WAIT_NS   1000
`define MWIC_INIT_CAL_NS     1000
`define MWIC_LONG_CAL_NS     360
`define MWIC_SHORT_CAL_NS    90
`define MWIC_DFLT_CAL_NS     50
`define MWIC_SHORT_EVERY_CYC 100000

// ==========================================================================
// Command/address field positions
// ==========================================================================
`define MWIC_OPC_HI          3
`define MWIC_RADDR_HI        9
`define MWIC_RADDR_LO        4
`define MWIC_FADDR_HI        1
`define MWIC_DATA_HI         9
`define MWIC_DATA_LO         2
`define MWIC_NOP_CODE        3'h7

// ==========================================================================
// Addresses, codes and reset values
// ==========================================================================
`define MWIC_SOFT_RESET_ADDR 8'h3f
`define MWIC_CAL_REG_ADDR    8'h0a
`define MWIC_NUM_REGS        64
`define MWIC_RO_MASK         64'h0000_0000_0000_01f1
`define MWIC_REG_DEFAULT     8'h00
`define MWIC_CODE_INIT       8'h01
`define MWIC_CODE_DFLT       8'h02
`define MWIC_CODE_LONG       8'h03
`define MWIC_CODE_SHORT      8'h04

`endif

// *** verilog/mwic_pkg.sv ***
// Types and shared helpers for the configuration write block.
`include "mwic_defines.svh"

package mwic_pkg;

  // ========================================================================
  // Types
  // ========================================================================
  typedef enum logic [2:0] {
    CAL_NONE  = 3'b000,
    CAL_INIT  = 3'b001,
    CAL_DFLT  = 3'b010,
    CAL_LONG  = 3'b011,
    CAL_SHORT = 3'b100
  } mwic_cal_t;

  typedef enum logic [1:0] {
    DEV_IDLE      = 2'b00,
    DEV_CFG_WAIT  = 2'b01,
    DEV_CAL       = 2'b10,
    DEV_RESETTING = 2'b11
  } mwic_dev_state_t;

  typedef enum logic [0:0] {
    HOST_IDLE = 1'b0,
    HOST_WAIT = 1'b1
  } mwic_host_state_t;

  // ========================================================================
  // Helpers
  // ========================================================================
  // Maps a write to the calibration register onto an operation.
  function automatic mwic_cal_t mwicCalKind(input logic [7:0] addr,
                                            input logic [7:0] data,
                                            input logic [7:0] cInit,
                                            input logic [7:0] cDflt,
                                            input logic [7:0] cLong,
                                            input logic [7:0] cShort);
    mwic_cal_t k;
    k = CAL_NONE;
    if (addr == `MWIC_CAL_REG_ADDR) begin
      if (data == cInit) k = CAL_INIT;
      else if (data == cDflt) k = CAL_DFLT;
      else if (data == cLong) k = CAL_LONG;
      else if (data == cShort) k = CAL_SHORT;
    end
    return k;
  endfunction

  // Cycles from the command edge until the next command may be taken.
  function automatic logic [11:0] mwicWaitCycles(input logic [7:0] addr,
                                                 input mwic_cal_t kind);
    logic [11:0] n;
    n = `MWIC_CFG_WRITE_CYC;
    case (kind)
      CAL_INIT:  n = `MWIC_CYC(`MWIC_INIT_CAL_NS);
      CAL_DFLT:  n = `MWIC_CYC(`MWIC_DFLT_CAL_NS);
      CAL_LONG:  n = `MWIC_CYC(`MWIC_LONG_CAL_NS);
      CAL_SHORT: n = `MWIC_CYC(`MWIC_SHORT_CAL_NS);
      default:   n = `MWIC_CFG_WRITE_CYC;
    endcase
    if (addr == `MWIC_SOFT_RESET_ADDR) n = `MWIC_CYC(`MWIC_RESET_WAIT_NS);
    return n;
  endfunction

endpackage

// *** verilog/mwic_ca_if.sv ***
// Command/address link between the memory controller and the memory device.
interface mwic_ca_if;
  logic       csN;     // Chip select, active low.
  logic       cke;     // Clock gate, high while running.
  logic [9:0] caRise;  // Lines sampled at the rising edge.
  logic [9:0] caFall;  // Lines sampled at the falling edge.

  modport dev (input csN, input cke, input caRise, input caFall);
  modport host (output csN, output cke, output caRise, output caFall);
endinterface

// *** verilog/mwic_host.sv ***
// Memory controller end: issues configuration writes and keeps the gaps.
`include "mwic_defines.svh"
module mwic_host
  import mwic_pkg::*;
#(
  parameter logic [7:0]  CODE_INIT   = `MWIC_CODE_INIT,       // Initial calibration code.
  parameter logic [7:0]  CODE_DFLT   = `MWIC_CODE_DFLT,       // Reset-to-default code.
  parameter logic [7:0]  CODE_LONG   = `MWIC_CODE_LONG,       // Long calibration code.
  parameter logic [7:0]  CODE_SHORT  = `MWIC_CODE_SHORT,      // Short calibration code.
  parameter logic [31:0] SHORT_EVERY = `MWIC_SHORT_EVERY_CYC  // Auto short interval.
) (
  input  wire logic       clk,         // 250 MHz clock.
  input  wire logic       reset,       // Synchronous, active high.
  mwic_ca_if.host         ca,          // Command/address link.
  input  wire logic       reqValid,    // User write request.
  input  wire logic [7:0] reqAddr,     // Register address.
  input  wire logic [7:0] reqData,     // Register data.
  output logic            reqReady,    // Request taken when valid and ready.
  input  wire logic       banksIdle,   // All banks precharged.
  input  wire logic       refFree,     // Shared reference not claimed by another.
  input  wire logic       autoShortEn, // Enable periodic short calibration.
  output logic            refClaim,    // This device holds the shared reference.
  output logic            dqQuiet,     // Data bus must stay released.
  output logic            busy,        // A wait period is running.
  output logic            initCalDone  // Initial calibration issued.
);

  // ========================================================================
  // Request qualification
  // ========================================================================
  mwic_host_state_t state_q;
  logic [11:0] cnt_q;
  logic [31:0] timer_q;
  logic        autoDue_q;
  mwic_cal_t   userCal;
  mwic_cal_t   issueCal;
  logic [7:0]  issueAddr;
  logic [7:0]  issueData;
  logic        userOk;
  logic        autoGo;
  logic        issue;
  logic [11:0] waitCyc;

  assign userCal = mwicCalKind(reqAddr, reqData, CODE_INIT, CODE_DFLT, CODE_LONG, CODE_SHORT);

  // Only from idle with banks precharged; long and short need a prior
  // initial calibration; non-default ones need the reference free.
  assign userOk = (state_q == HOST_IDLE) & banksIdle & ~autoDue_q
                & (((userCal != CAL_LONG) & (userCal != CAL_SHORT)) | initCalDone)
                & (((userCal == CAL_NONE) | (userCal == CAL_DFLT)) | refFree);
  assign reqReady = userOk;
  assign autoGo = (state_q == HOST_IDLE) & banksIdle & autoDue_q & refFree;
  assign issue = autoGo | (reqValid & userOk);
  assign issueAddr = autoGo ? `MWIC_CAL_REG_ADDR : reqAddr;
  assign issueData = autoGo ? CODE_SHORT : reqData;
  assign issueCal = autoGo ? CAL_SHORT : userCal;
  assign waitCyc = mwicWaitCycles(issueAddr, issueCal);

  // ========================================================================
  // Command driver
  // ========================================================================
  // Outside the command cycle the link carries deselect, a no-op.
  always_ff @(posedge clk) begin
    if (reset) begin
      ca.csN <= 1'b1;
      ca.cke <= 1'b1;
      ca.caRise <= 10'h3ff;
      ca.caFall <= 10'h3ff;
    end else begin
      ca.cke <= 1'b1;
      ca.csN <= ~issue;
      ca.caRise <= issue ? {issueAddr[5:0], 4'h0} : 10'h3ff;
      ca.caFall <= issue ? {issueData, issueAddr[7:6]} : 10'h3ff;
    end
  end

  // ========================================================================
  // Wait sequencer
  // ========================================================================
  // Holds off new commands for the whole period of the last one.
  always_ff @(posedge clk) begin
    if (reset) begin
      state_q <= HOST_IDLE;
      cnt_q <= 12'h000;
      dqQuiet <= 1'b0;
    end else if (issue && (waitCyc > 12'h001)) begin
      state_q <= HOST_WAIT;
      cnt_q <= waitCyc;  // The device takes the command one edge later.
      dqQuiet <= (issueCal == CAL_INIT) | (issueCal == CAL_LONG)
               | (issueCal == CAL_SHORT);
    end else if ((state_q == HOST_WAIT) && (cnt_q == 12'h001)) begin
      state_q <= HOST_IDLE;
      cnt_q <= 12'h000;
      dqQuiet <= 1'b0;
    end else if (state_q == HOST_WAIT) begin
      cnt_q <= cnt_q - 12'h001;
    end
  end

  // The reference claim covers exactly the quiet calibration periods.
  assign refClaim = dqQuiet;
  assign busy = (state_q == HOST_WAIT);

  // ========================================================================
  // Initial calibration tracking and periodic short calibration
  // ========================================================================
  // A soft reset returns the device to boot, so calibration starts over.
  always_ff @(posedge clk) begin
    if (reset) begin
      initCalDone <= 1'b0;
    end else if (issue && (issueAddr == `MWIC_SOFT_RESET_ADDR)) begin
      initCalDone <= 1'b0;
    end else if (issue && (issueCal == CAL_INIT)) begin
      initCalDone <= 1'b1;
    end
  end

  // The interval timer restarts on any short calibration.
  always_ff @(posedge clk) begin
    if (reset || !autoShortEn || !initCalDone) begin
      timer_q <= 32'h0000_0000;
      autoDue_q <= 1'b0;
    end else if (issue && (issueCal == CAL_SHORT)) begin
      timer_q <= 32'h0000_0000;
      autoDue_q <= 1'b0;
    end else if (timer_q >= SHORT_EVERY - 32'h0000_0001) begin
      autoDue_q <= 1'b1;
    end else begin
      timer_q <= timer_q + 32'h0000_0001;
    end
  end

endmodule

// *** bench/mwic_asserts.sv ***
// Concurrent checks on the command link between the controller and device ends.
module mwic_asserts
  import mwic_pkg::*;
(
  input wire logic       clk,          // Clock.
  input wire logic       reset,        // Synchronous, active high.
  input wire logic       csN,          // Chip select, active low.
  input wire logic       cke,          // Clock gate.
  input wire logic [9:0] caRise,       // Rising-edge lines.
  input wire logic [9:0] caFall,       // Falling-edge lines.
  input wire logic       busy,         // Device period running.
  input wire logic       calActive,    // Device calibrating.
  input wire mwic_cal_t  calKind,      // Calibration now running.
  input wire logic       zqCurrentOn,  // Reference current path.
  input wire logic       arrayLost,    // Array contents lost pulse.
  input wire logic       cmdViolation, // Command seen while busy.
  input wire logic       dqQuiet       // Controller keeps data bus released.
);
  timeunit 1ns;
  timeprecision 1ps;
  // ========================================================================
  // Command decode
  // ========================================================================
  // The link carries both device clock edges in one cycle, so decode here.
  logic       wrCmd;
  logic [7:0] wrAddr;
  assign wrCmd  = !csN && (caRise[3:0] == 4'h0);
  assign wrAddr = {caFall[1:0], caRise[9:4]};

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  // A plain write lasts five cycles: busy four cycles after the command, then idle.
  sequence s_plain_write;
    wrCmd && !busy && (wrAddr != 8'h0a) && (wrAddr != 8'h3f);
  endsequence
  sequence s_period5;
    busy [*4] ##1 !busy;
  endsequence

  // ========================================================================
  // Properties
  // ========================================================================
  a_cmd_one_cycle: assert property (!csN |=> csN)
    else $error("command held longer than one cycle");
  a_plain_period: assert property (s_plain_write |=> s_period5)
    else $error("plain write period is not five cycles");
  a_write_busy: assert property (wrCmd && !busy |=> busy)
    else $error("write command not taken");
  a_no_cmd_busy: assert property (busy |-> csN)
    else $error("command issued during a busy period");
  a_cke_during_cal: assert property (calActive |-> cke && csN)
    else $error("clock gate low or command during calibration");
  a_quiet_cal: assert property (calActive && calKind != CAL_DFLT |-> dqQuiet)
    else $error("data bus not quiet during calibration");
  a_current_off_idle: assert property (!busy |-> !zqCurrentOn)
    else $error("reference current left on while idle");
  a_cal_current: assert property ($rose(calActive) |-> zqCurrentOn)
    else $error("calibration started without reference current");
  a_reset_lost: assert property (wrCmd && !busy && wrAddr == 8'h3f |-> ##[1:2] arrayLost)
    else $error("soft reset gave no array loss pulse");
  a_no_violation: assert property (!cmdViolation)
    else $error("device flagged a command during a busy period");
endmodule

// *** bench/testbench.sv ***
// Self-checking bench joining the controller and device ends over the command link.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import mwic_pkg::*;

  logic       clk = 1'b0, reset = 1'b1, reqValid = 1'b0, reqReady, banksIdle = 1'b1;
  logic       refFree = 1'b1, autoShort = 1'b0, zqTie = 1'b0, hBusy, dBusy, calActive;
  logic       zqOn, drvCal, lost, viol, violB, dqQuiet, initDone, refClaim;
  logic       sawCal = 1'b0, sawZq = 1'b0, sawLost = 1'b0, sawViol = 1'b0;
  logic [7:0] reqAddr = 8'h00, reqData = 8'h00, rdData, rdDataB;
  logic [5:0] rdAddr = 6'h00, rdAddrB = 6'h02;
  mwic_cal_t  calKind, lastKind;
  int         n_fail = 0, check_count = 0, cnt, k;
  // Calibration table: code, busy cycles, expect calibration, kind, drivers calibrated.
  logic [7:0] codes [5] = '{8'h01, 8'h03, 8'h04, 8'h02, 8'h09};
  int         per   [5] = '{249, 89, 22, 12, 4};
  logic       exCal [5] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
  mwic_cal_t  exKind [5] = '{CAL_INIT, CAL_LONG, CAL_SHORT, CAL_DFLT, CAL_DFLT};
  logic       exDrv [5] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
  mwic_ca_if  link ();
  mwic_ca_if  linkB ();

  mwic_host #(.SHORT_EVERY(32'd50)) i_mwic_host (.clk(clk), .reset(reset), .ca(link.host),
    .reqValid(reqValid), .reqAddr(reqAddr), .reqData(reqData), .reqReady(reqReady),
    .banksIdle(banksIdle), .refFree(refFree), .autoShortEn(autoShort), .refClaim(refClaim),
    .dqQuiet(dqQuiet), .busy(hBusy), .initCalDone(initDone));
  mwic_device i_mwic_device (.clk(clk), .reset(reset), .ca(link.dev), .zqTiedToSupply(zqTie),
    .rdAddr(rdAddr), .rdData(rdData), .busy(dBusy), .calActive(calActive), .calKind(calKind),
    .zqCurrentOn(zqOn), .driverCalibrated(drvCal), .arrayLost(lost), .cmdViolation(viol));
  // Second device faces a bench driver that breaks the command spacing on purpose.
  mwic_device i_mwic_device_b (.clk(clk), .reset(reset), .ca(linkB.dev), .zqTiedToSupply(1'b0),
    .rdAddr(rdAddrB), .rdData(rdDataB), .busy(), .calActive(), .calKind(), .zqCurrentOn(),
    .driverCalibrated(), .arrayLost(), .cmdViolation(violB));
  mwic_asserts i_mwic_asserts (.clk(clk), .reset(reset), .csN(link.csN), .cke(link.cke),
    .caRise(link.caRise), .caFall(link.caFall), .busy(dBusy), .calActive(calActive),
    .calKind(calKind), .zqCurrentOn(zqOn), .arrayLost(lost), .cmdViolation(viol),
    .dqQuiet(dqQuiet));

  // Free-running 250 MHz clock.
  always #2 clk = ~clk;

  // Sticky flags catch one-cycle pulses that the tasks would otherwise miss.
  always @(posedge clk) begin
    if (calActive === 1'b1) sawCal <= 1'b1;
    if (calActive === 1'b1) lastKind <= calKind;
    if (zqOn === 1'b1) sawZq <= 1'b1;
    if (lost === 1'b1) sawLost <= 1'b1;
    if (violB === 1'b1) sawViol <= 1'b1;
  end

  // ========================================================================
  // Tasks
  // ========================================================================
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One user request; n returns the cycles the device stays busy.
  task automatic wr(input logic [7:0] a, input logic [7:0] d, output int n);
    @(negedge clk);
    reqAddr = a;
    reqData = d;
    reqValid = 1'b1;
    while (reqReady !== 1'b1) @(negedge clk);
    @(negedge clk);
    reqValid = 1'b0;
    n = 0;
    @(negedge clk);
    while (dBusy === 1'b1 && n < 2000) begin
      n++;
      @(negedge clk);
    end
  endtask

  task automatic rd(input logic [5:0] a, input logic [7:0] exp);
    @(negedge clk);
    rdAddr = a;
    @(negedge clk);
    check(rdData, exp);
  endtask

  // Raw command on the second link; released lines show the inverse value.
  task automatic raw(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    linkB.csN = 1'b0;
    linkB.caRise = {a[5:0], 4'h0};
    linkB.caFall = {d, a[7:6]};
    @(negedge clk);
    linkB.csN = 1'b1;
    linkB.caRise = ~linkB.caRise;
    linkB.caFall = ~linkB.caFall;
  endtask

  task automatic finish_test();
    $display("checks %0d failures %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ========================================================================
  // Main sequence
  // ========================================================================
  initial begin
    linkB.csN = 1'b1;
    linkB.cke = 1'b1;
    linkB.caRise = 10'h3ff;
    linkB.caFall = 10'h3ff;
    repeat (4) @(negedge clk);
    reset = 1'b0;
    repeat (3) @(negedge clk);
    rd(6'h0a, 8'h00);
    // Busy banks and a claimed reference both hold the request back.
    reqValid = 1'b1;
    banksIdle = 1'b0;
    @(negedge clk);
    check(8'(reqReady), 8'h00);
    banksIdle = 1'b1;
    refFree = 1'b0;
    reqAddr = 8'h0a;
    reqData = 8'h01;
    @(negedge clk);
    check(8'(reqReady), 8'h00);
    reqValid = 1'b0;
    refFree = 1'b1;
    for (int i = 0; i < 5; i++) begin
      sawCal = 1'b0;
      sawZq = 1'b0;
      wr(8'h0a, codes[i], cnt);
      check(8'(cnt), 8'(per[i]));
      check(8'(sawCal), 8'(exCal[i]));
      check(8'(lastKind), 8'(exKind[i]));
      check(8'({sawZq, zqOn}), 8'({exCal[i], 1'b0}));
      check(8'(drvCal), 8'(exDrv[i]));
    end
    // Back-to-back plain writes: address halves, read-only target, data field.
    wr(8'h02, 8'h3c, cnt);
    check(8'(cnt), 8'd4);
    wr(8'h42, 8'hff, cnt);
    wr(8'h04, 8'h77, cnt);
    wr(8'h3e, 8'ha5, cnt);
    rd(6'h02, 8'h3c);
    rd(6'h04, 8'h00);
    rd(6'h3e, 8'ha5);
    // Periodic short calibration started by the controller on its own.
    autoShort = 1'b1;
    for (k = 0; k < 300 && calActive !== 1'b1; k++) @(negedge clk);
    check(8'(calKind), 8'(CAL_SHORT));
    check(8'({refClaim, dqQuiet}), 8'h03);
    autoShort = 1'b0;
    for (k = 0; k < 300 && hBusy !== 1'b0; k++) @(negedge clk);
    sawLost = 1'b0;
    wr(8'h3f, 8'h00, cnt);
    check(8'(cnt), 8'd249);
    check(8'({sawLost, initDone, drvCal}), 8'h04);
    rd(6'h3e, 8'h00);
    // Strapped reference: calibration becomes a plain write.
    zqTie = 1'b1;
    repeat (3) @(negedge clk);
    sawCal = 1'b0;
    sawZq = 1'b0;
    wr(8'h0a, 8'h01, cnt);
    check(8'(cnt), 8'd4);
    check(8'({sawCal, sawZq, drvCal}), 8'h00);
    // Second command inside the write period is ignored and flagged.
    raw(8'h02, 8'h11);
    raw(8'h02, 8'h22);
    repeat (8) @(negedge clk);
    check(8'(sawViol), 8'h01);
    check(rdDataB, 8'h11);
    finish_test();
  end

  // Watchdog: the sequence needs well under 3000 cycles.
  initial begin
    #40000;
    n_fail++;
    finish_test();
  end
endmodule
